/* File: design/rfa_bank.v */
// Management register bank showing each bit access attribute
// Overview of operation
// - Read-only bits return their value; writes leave them unchanged.
// - Write-only bits read back unspecified data; managers must not trust it.
// - Write-one-to-clear bits clear on a written one, keep on zero.
// - Write-anything-to-clear bits clear on any write, whatever the data.
// - Read-to-clear field returns contents, then clears; writes do nothing.
// - Latch-low bit holds its low until the register is read.
// - Self-clearing bit returns to zero by itself; writing zero does nothing.
// - Self-setting bit returns to one by itself; writing one does nothing.
// - Sticky high status stays high until read, then follows the condition.
// - Soft-reset-immune bits keep their values through a software reset.
// - Managers write zeros to reserved bits; their read value is unguaranteed.
// - Read-write bits accept writes and read back their held setting.
// - Readable any-write-clear bits read current value, clear on any write.
// - Hardware reset restores all defaults; software reset restores all but immune bits.
// - Registers are addressed by decimal register index.
`timescale 1ns/10ps
`include "rfa_defs.vh"

module rfa_bank #(
  parameter DW = 16,
  parameter IW = 5
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Management access port, same clock domain
  input wire [IW-1:0] acc_index,
  input wire acc_wr,
  input wire acc_rd,
  input wire [DW-1:0] acc_wdata,
  output reg [DW-1:0] acc_rdata_reg,
  output reg acc_rvalid_reg,
  // Device conditions and events, same clock domain
  input wire [DW-1:0] status_in,
  input wire [DW-1:0] event_in,
  input wire count_inc,
  // Control outputs
  output reg [DW-1:0] ctrl_out_reg,
  output reg [DW-1:0] wonly_out_reg,
  output reg soft_rst_out_reg
);

  wire [DW-1:0] ctrl_q;
  wire [DW-1:0] stat_q;
  wire [DW-1:0] evt_q;
  wire soft_rst;
  reg [DW-1:0] cnt_reg;
  reg [DW-1:0] cnt_next;
  reg [DW-1:0] wonly_reg;
  reg [DW-1:0] rdata_next;
  localparam [63:0] CTRL_ATTRS = `RFA_CTRL_ATTRS;
  localparam [63:0] STAT_ATTRS = `RFA_STAT_ATTRS;
  localparam [63:0] EVT_ATTRS = `RFA_EVT_ATTRS;
  localparam [DW-1:0] CTRL_DEF = `RFA_CTRL_DEFAULT;
  localparam [DW-1:0] STAT_DEF = `RFA_STAT_DEFAULT;
  localparam [DW-1:0] EVT_DEF = `RFA_EVT_DEFAULT;

  // Register map, index in decimal
  //   0 control: bit 15 starts a software reset and clears itself,
  //     bits 14:12 read-write, bit 11 sets itself again after a clear,
  //     bits 10:8 read-write and kept through a software reset,
  //     bits 7:0 reserved, held at zero
  //   1 status: bits 15:8 follow the condition inputs a cycle late,
  //     bits 7:4 stay high until read, bits 3:0 stay low until read
  //   2 events: bits 15:8 clear on a written one,
  //     bits 7:0 clear on any write
  //   3 counter: counts increments, saturates, clears when read
  //   4 write-only word, reads as zero, mirrored on its own output
  //   other indices read as zero and ignore writes
  // Reads answer a cycle after the strobe with the value held before it;
  // a read and a write in one cycle see the old value.

  // Index match, used for both read and write decode
  function sel;
    input [IW-1:0] idx;
    input [IW-1:0] target;
    begin
      sel = (idx == target);
    end
  endfunction

  wire wr_ctrl = acc_wr & sel(acc_index, `RFA_IDX_CTRL);
  wire wr_stat = acc_wr & sel(acc_index, `RFA_IDX_STAT);
  wire wr_evt = acc_wr & sel(acc_index, `RFA_IDX_EVT);
  wire wr_wonly = acc_wr & sel(acc_index, `RFA_IDX_WONLY);
  wire rd_ctrl = acc_rd & sel(acc_index, `RFA_IDX_CTRL);
  wire rd_stat = acc_rd & sel(acc_index, `RFA_IDX_STAT);
  wire rd_evt = acc_rd & sel(acc_index, `RFA_IDX_EVT);
  wire rd_cnt = acc_rd & sel(acc_index, `RFA_IDX_CNT);

  // Self-clearing control bit drives the software reset for one cycle
  assign soft_rst = ctrl_q[`RFA_CTRL_SOFT_RST];

  genvar i;
  generate
    for (i = 0; i < DW; i = i + 1)
    begin : g_bits
      rfa_bit #(
        .ATTR(CTRL_ATTRS[4*i+3:4*i]),
        .DEFAULT(CTRL_DEF[i])
      ) u_ctrl (
        .clk(clk),
        .rstn(rstn),
        .soft_rst(soft_rst),
        .wr(wr_ctrl),
        .rd(rd_ctrl),
        .wd(acc_wdata[i]),
        .hw(1'b0),
        .q_reg(ctrl_q[i])
      );
      // Status writes are routed in but every bit ignores them
      rfa_bit #(
        .ATTR(STAT_ATTRS[4*i+3:4*i]),
        .DEFAULT(STAT_DEF[i])
      ) u_stat (
        .clk(clk),
        .rstn(rstn),
        .soft_rst(soft_rst),
        .wr(wr_stat),
        .rd(rd_stat),
        .wd(acc_wdata[i]),
        .hw(status_in[i]),
        .q_reg(stat_q[i])
      );
      rfa_bit #(
        .ATTR(EVT_ATTRS[4*i+3:4*i]),
        .DEFAULT(EVT_DEF[i])
      ) u_evt (
        .clk(clk),
        .rstn(rstn),
        .soft_rst(soft_rst),
        .wr(wr_evt),
        .rd(rd_evt),
        .wd(acc_wdata[i]),
        .hw(event_in[i]),
        .q_reg(evt_q[i])
      );
    end
  endgenerate

  // Read-to-clear counter; an increment in the read cycle survives as one
  always @*
  begin
    cnt_next = cnt_reg;
    if (rd_cnt)
      cnt_next = count_inc ? `RFA_CNT_ONE : `RFA_ZERO16;
    else if (count_inc && cnt_reg != `RFA_CNT_MAX)
      cnt_next = cnt_reg + `RFA_CNT_ONE;
  end

  // Read data mux; write-only and unmapped indices read as zero
  always @*
  begin
    rdata_next = `RFA_ZERO16;
    case (acc_index)
      `RFA_IDX_CTRL: rdata_next = ctrl_q;
      `RFA_IDX_STAT: rdata_next = stat_q;
      `RFA_IDX_EVT: rdata_next = evt_q;
      `RFA_IDX_CNT: rdata_next = cnt_reg;
      `RFA_IDX_WONLY: rdata_next = `RFA_ZERO16;
      default: rdata_next = `RFA_ZERO16;
    endcase
  end

  // Counter register
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= `RFA_CNT_DEFAULT;
    else if (soft_rst)
      cnt_reg <= `RFA_CNT_DEFAULT;
    else
      cnt_reg <= cnt_next;
  end

  // Write-only word
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wonly_reg <= `RFA_WONLY_DEFAULT;
    else if (soft_rst)
      wonly_reg <= `RFA_WONLY_DEFAULT;
    else if (wr_wonly)
      wonly_reg <= acc_wdata;
  end

  // Read answer; data stays until the next read
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_rdata_reg <= `RFA_ZERO16;
      acc_rvalid_reg <= 1'b0;
    end
    else
    begin
      acc_rvalid_reg <= acc_rd;
      if (acc_rd)
        acc_rdata_reg <= rdata_next;
    end
  end

  // Control mirrors, one cycle behind the bits themselves
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_out_reg <= CTRL_DEF;
      soft_rst_out_reg <= 1'b0;
    end
    else
    begin
      ctrl_out_reg <= ctrl_q;
      soft_rst_out_reg <= soft_rst;
    end
  end

  // Write-only word mirror
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wonly_out_reg <= `RFA_WONLY_DEFAULT;
    else
      wonly_out_reg <= wonly_reg;
  end

endmodule // rfa_bank

/* File: design/rfa_bit.v */
// One management register bit with a selectable access attribute
`timescale 1ns/10ps
`include "rfa_defs.vh"

module rfa_bit #(
  parameter [3:0] ATTR = `RFA_ATTR_RW,
  parameter [0:0] DEFAULT = 1'b0
) (
  // Clock and resets
  input wire clk,
  input wire rstn,
  input wire soft_rst,
  // Access strobes for the owning register
  input wire wr,
  input wire rd,
  input wire wd,
  // Hardware condition or event
  input wire hw,
  // Held value
  output reg q_reg
);

  reg q_next;

  always @*
  begin
    q_next = q_reg;
    case (ATTR)
      `RFA_ATTR_RW, `RFA_ATTR_RWN:
        if (wr) q_next = wd;
      `RFA_ATTR_READ_ONLY:
        q_next = hw;
      `RFA_ATTR_ONE_CLR:
        q_next = hw | (q_reg & ~(wr & wd));
      `RFA_ATTR_ANY_CLR, `RFA_ATTR_READ_ANY_CLR:
        q_next = hw | (q_reg & ~wr);
      `RFA_ATTR_LATCH_LOW:
        q_next = rd ? hw : (q_reg & hw);
      `RFA_ATTR_LATCH_HIGH:
        q_next = hw | (q_reg & ~rd);
      `RFA_ATTR_SELF_CLR:
        q_next = wr & wd;
      `RFA_ATTR_SS:
        q_next = ~(wr & ~wd);
      default:
        q_next = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      q_reg <= DEFAULT;
    else if (soft_rst && ATTR != `RFA_ATTR_RWN)
      q_reg <= DEFAULT;
    else
      q_reg <= q_next;
  end

endmodule // rfa_bit

/* File: design/rfa_defs.vh */
// Constants for the register field access bank
`ifndef RFA_DEFS_VH
`define RFA_DEFS_VH

// Register indices, decimal as addressed over the management interface
`define RFA_IDX_CTRL 5'h00
`define RFA_IDX_STAT 5'h01
`define RFA_IDX_EVT 5'h02
`define RFA_IDX_CNT 5'h03
`define RFA_IDX_WONLY 5'h04

// Bit attribute codes
`define RFA_ATTR_RES 4'h0
`define RFA_ATTR_RW 4'h1
`define RFA_ATTR_READ_ONLY 4'h2
`define RFA_ATTR_ONE_CLR 4'h3
`define RFA_ATTR_ANY_CLR 4'h4
`define RFA_ATTR_LATCH_LOW 4'h5
`define RFA_ATTR_LATCH_HIGH 4'h6
`define RFA_ATTR_SELF_CLR 4'h7
`define RFA_ATTR_SS 4'h8
`define RFA_ATTR_RWN 4'h9
`define RFA_ATTR_READ_ANY_CLR 4'hA

// Attribute maps, one nibble per bit, bit 15 in the top nibble
`define RFA_CTRL_ATTRS 64'h7111899900000000
`define RFA_STAT_ATTRS 64'h2222222266665555
`define RFA_EVT_ATTRS 64'h33333333AAAAAAAA

// Default values
`define RFA_CTRL_DEFAULT 16'h0800
`define RFA_STAT_DEFAULT 16'h000F
`define RFA_EVT_DEFAULT 16'h0000
`define RFA_CNT_DEFAULT 16'h0000
`define RFA_WONLY_DEFAULT 16'h0000
`define RFA_ZERO16 16'h0000
`define RFA_CNT_MAX 16'hFFFF
`define RFA_CNT_ONE 16'h0001

// Field positions
`define RFA_CTRL_SOFT_RST 15

`endif

/* File: testbench/rfa_bank_chk.sv */
// Assertion checker for the register field access bank
`timescale 1ns/10ps
module rfa_bank_chk #(
  parameter DW = 16,
  parameter IW = 5
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Access port
  input wire [IW-1:0] acc_index,
  input wire acc_wr,
  input wire acc_rd,
  input wire [DW-1:0] acc_wdata,
  input wire [DW-1:0] acc_rdata_reg,
  input wire acc_rvalid_reg,
  // Device side
  input wire [DW-1:0] status_in,
  input wire count_inc,
  input wire [DW-1:0] ctrl_out_reg,
  input wire soft_rst_out_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rd_answer: assert property (acc_rd |=> acc_rvalid_reg)
    else $error("read not answered");
  a_rdata_hold: assert property (!acc_rvalid_reg |-> $stable(acc_rdata_reg))
    else $error("read data moved");
  a_wonly_rd_zero: assert property (acc_rd && acc_index == 4 |=> acc_rdata_reg == 0)
    else $error("write-only read not zero");
  a_stat_level: assert property (acc_rd && acc_index == 1 && !soft_rst_out_reg |=>
    acc_rdata_reg[15:8] == $past(status_in[15:8], 2))
    else $error("status bits wrong");
  a_cnt_clear: assert property (acc_rd && acc_index == 3 && !count_inc ##1 !count_inc
    ##1 acc_rd && acc_index == 3 |=> acc_rdata_reg == 0)
    else $error("counter not cleared");
  a_ctrl_write: assert property (!$past(acc_wr) && acc_wr && acc_index == 0
    && !acc_wdata[15] ##1 !acc_wr |=> ctrl_out_reg[14:12] == $past(acc_wdata[14:12], 2))
    else $error("control write lost");
  a_soft_pulse: assert property (acc_wr && acc_index == 0 && acc_wdata[15]
    |-> ##[2:3] soft_rst_out_reg)
    else $error("no soft reset pulse");
  a_ctrl_reserved: assert property (ctrl_out_reg[7:0] == 8'h00)
    else $error("reserved bits set");
  c_soft: cover property (soft_rst_out_reg);
  c_cnt: cover property (acc_rd && acc_index == 3 ##1 acc_rdata_reg != 0);
  c_stat: cover property (acc_rd && acc_index == 1);
endmodule // rfa_bank_chk

bind rfa_bank rfa_bank_chk #(.DW(DW), .IW(IW)) i_chk (.clk(clk), .rstn(rstn),
  .acc_index(acc_index), .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_wdata(acc_wdata),
  .acc_rdata_reg(acc_rdata_reg), .acc_rvalid_reg(acc_rvalid_reg),
  .status_in(status_in), .count_inc(count_inc), .ctrl_out_reg(ctrl_out_reg),
  .soft_rst_out_reg(soft_rst_out_reg));

/* File: testbench/tb.sv */
// Self-checking bench for the register field access bank
`timescale 1ns/10ps
module tb;
  reg clk, rstn, acc_wr, acc_rd, count_inc;
  reg [4:0] acc_index, a;
  reg [15:0] acc_wdata, status_in, event_in, rnd, w, e;
  wire [15:0] acc_rdata_reg, ctrl_out_reg, wonly_out_reg;
  wire acc_rvalid_reg, soft_rst_out_reg;
  integer fail_count, checks, cyc, i, n;
  rfa_bank i_dut (.clk(clk), .rstn(rstn), .acc_index(acc_index), .acc_wr(acc_wr),
    .acc_rd(acc_rd), .acc_wdata(acc_wdata), .acc_rdata_reg(acc_rdata_reg),
    .acc_rvalid_reg(acc_rvalid_reg), .status_in(status_in), .event_in(event_in),
    .count_inc(count_inc), .ctrl_out_reg(ctrl_out_reg), .wonly_out_reg(wonly_out_reg),
    .soft_rst_out_reg(soft_rst_out_reg));
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [79:0] nm, input [15:0] x, input [15:0] g);
    begin
      checks = checks + 1;
      if (g !== x)
      begin
        fail_count = fail_count + 1;
        $display("BAD %0s exp %h got %h", nm, x, g);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // Each access leaves one idle cycle behind it
  task wr(input [4:0] ix, input [15:0] d);
    begin
      acc_index = ix;
      acc_wdata = d;
      acc_wr = 1'b1;
      tick;
      acc_wr = 1'b0;
      tick;
    end
  endtask
  task rd(input [4:0] ix, input [15:0] x, input [79:0] nm);
    begin
      acc_index = ix;
      acc_rd = 1'b1;
      tick;
      acc_rd = 1'b0;
      chk(nm, x, acc_rdata_reg);
      chk("rvalid", 16'h0001, {15'h0000, acc_rvalid_reg});
      tick;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    cyc = 0;
    forever
    begin
      @(posedge clk);
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
        fail_count = fail_count + 1;
        test_done;
      end
    end
  end
  initial
  begin
    {rstn, acc_wr, acc_rd, count_inc} = 4'h0;
    acc_index = 5'h00;
    acc_wdata = 16'h0000;
    status_in = 16'h000F;
    event_in = 16'h0000;
    fail_count = 0;
    checks = 0;
    rnd = 16'h6A26;
    repeat (12) @(posedge clk);
    #1;
    rstn = 1'b1;
    rd(5'h00, 16'h0800, "ctrl rst");
    rd(5'h01, 16'h000F, "stat rst");
    for (i = 0; i < 6; i = i + 1)
    begin
      rnd = lfsr(rnd);
      w = rnd & 16'h7F00;
      wr(5'h00, w);
      rd(5'h00, {1'b0, w[14:12], 1'b1, w[10:8], 8'h00}, "ctrl");
      chk("ctrl out", {1'b0, w[14:12], 1'b1, w[10:8], 8'h00}, ctrl_out_reg);
      wr(5'h00, 16'h8000 | w);
      chk("srst out", 16'h0001, {15'h0000, soft_rst_out_reg});
      repeat (3) tick;
      rd(5'h00, {5'h01, w[10:8], 8'h00}, "ctrl srst");
      n = rnd[2:0] + 1;
      count_inc = 1'b1;
      repeat (n) tick;
      count_inc = 1'b0;
      wr(5'h03, 16'hFFFF);
      rd(5'h03, n[15:0], "cnt");
      rd(5'h03, 16'h0000, "cnt clr");
      e = lfsr(rnd);
      event_in = e;
      tick;
      event_in = 16'h0000;
      rd(5'h02, e, "evt");
      wr(5'h02, rnd);
      rd(5'h02, {e[15:8] & ~rnd[15:8], 8'h00}, "evt clr");
      status_in = {e[15:8], 8'hF0};
      tick;
      status_in = {e[15:8], 8'h0F};
      wr(5'h01, 16'hFFFF);
      rd(5'h01, {e[15:8], 8'hF0}, "stat lat");
      rd(5'h01, {e[15:8], 8'h0F}, "stat now");
      wr(5'h04, rnd);
      chk("wonly out", rnd, wonly_out_reg);
      rd(5'h04, 16'h0000, "wonly rd");
      a = {1'b1, rnd[3:0]};
      wr(a, rnd);
      rd(a, 16'h0000, "unmapped");
      $display("loop %0d done", i);
    end
    test_done;
  end
endmodule // tb
